//--- rtl/line_transceiver_shutdown_ctrl.sv
`timescale 1ns/100ps
module line_transceiver_shutdown_ctrl #(
  parameter int unsigned CHANNELS = 2,
  parameter longint unsigned IDLE_CYCLES = line_xcvr_pkg::IDLE_CYC,
  parameter bit AUTO_VARIANT = 1'b1
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic tx_power_down_n_i,
  input wire logic rx_drive_gate_n_i,
  input wire logic hold_awake_i,
  input wire logic hold_asleep_n_i,
  input wire logic [CHANNELS-1:0] tx_logic_in_i,
  input wire logic [CHANNELS-1:0] rx_line_in_i,
  input wire logic [CHANNELS-1:0] rx_level_valid_i,
  input wire logic neg_rail_at_3v_i,
  input wire logic neg_rail_at_2v75_i,
  output logic [CHANNELS-1:0] tx_line_out_o,
  output logic [CHANNELS-1:0] tx_line_oe_o,
  output logic [CHANNELS-1:0] rx_logic_out_o,
  output logic [CHANNELS-1:0] rx_logic_oe_o,
  output logic pump_enable_o,
  output logic ready_o,
  output logic line_level_present_o,
  output line_xcvr_pkg::status_type status_o
);
  import line_xcvr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [CHANNELS-1:0] tx_s1_q, tx_s2_q, tx_s3_q;
  logic [CHANNELS-1:0] rx_s1_q, rx_s2_q, rx_s3_q;
  logic [CHANNELS-1:0] lvl_s1_q, lvl_s2_q;
  logic [1:0] ctl_s1_q, ctl_s2_q;
  logic [1:0] ovr_s1_q, ovr_s2_q;
  logic [1:0] rail_s1_q, rail_s2_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_s1_q <= '0;
      tx_s2_q <= '0;
      tx_s3_q <= '0;
      rx_s1_q <= '0;
      rx_s2_q <= '0;
      rx_s3_q <= '0;
      lvl_s1_q <= '0;
      lvl_s2_q <= '0;
      ctl_s1_q <= SYNC_RESET;
      ctl_s2_q <= SYNC_RESET;
      ovr_s1_q <= SYNC_RESET;
      ovr_s2_q <= SYNC_RESET;
      rail_s1_q <= SYNC_RESET;
      rail_s2_q <= SYNC_RESET;
    end else begin
      tx_s1_q <= tx_logic_in_i;
      tx_s2_q <= tx_s1_q;
      tx_s3_q <= tx_s2_q;
      rx_s1_q <= rx_line_in_i;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      lvl_s1_q <= rx_level_valid_i;
      lvl_s2_q <= lvl_s1_q;
      ctl_s1_q <= {tx_power_down_n_i, rx_drive_gate_n_i};
      ctl_s2_q <= ctl_s1_q;
      ovr_s1_q <= {hold_awake_i, hold_asleep_n_i};
      ovr_s2_q <= ovr_s1_q;
      rail_s1_q <= {neg_rail_at_3v_i, neg_rail_at_2v75_i};
      rail_s2_q <= rail_s1_q;
    end
  end

  wire pwr_down_n = ctl_s2_q[1];
  wire rx_gate_n = ctl_s2_q[0];
  wire awake_force = ovr_s2_q[1];
  wire asleep_n = ovr_s2_q[0];
  wire rail_3v = rail_s2_q[1];
  wire rail_2v75 = rail_s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection per channel
  logic [CHANNELS-1:0] edge_vec;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_edge
      assign edge_vec[g] = (tx_s2_q[g] ^ tx_s3_q[g]) | (rx_s2_q[g] ^ rx_s3_q[g]);
    end
  endgenerate
  wire any_edge = |edge_vec;

  ////////////////////////////////////////////////////////////////////////////
  // inactivity timer
  logic [IDLE_CNT_W-1:0] idle_cnt_q, idle_cnt_d;
  logic idle_exp_q, idle_exp_d;
  localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(IDLE_CYCLES - 1);

  always_comb begin
    idle_cnt_d = idle_cnt_q;
    idle_exp_d = idle_exp_q;
    if (any_edge) begin
      idle_cnt_d = '0;
      idle_exp_d = 1'b0;
    end else if (idle_cnt_q == IDLE_LAST) begin
      idle_exp_d = 1'b1;
    end else begin
      idle_cnt_d = idle_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt_q <= '0;
      idle_exp_q <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_d;
      idle_exp_q <= idle_exp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power decision
  wire want_on_auto = asleep_n & (awake_force | ~idle_exp_q);
  wire want_on = AUTO_VARIANT ? want_on_auto : pwr_down_n;

  pwr_state_type state_q, state_d;
  logic [WAKE_CNT_W-1:0] wake_cnt_q, wake_cnt_d;
  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_DELAY_CYC - 1);

  always_comb begin
    state_d = state_q;
    wake_cnt_d = wake_cnt_q;
    unique case (state_q)
      ST_OFF: begin
        wake_cnt_d = '0;
        if (want_on) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!want_on) begin
          state_d = ST_OFF;
        end else if (wake_cnt_q == WAKE_LAST && rail_3v) begin
          state_d = ST_ON;
        end else if (wake_cnt_q != WAKE_LAST) begin
          wake_cnt_d = wake_cnt_q + 1'b1;
        end
      end
      ST_ON: begin
        if (!want_on) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_OFF;
      wake_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire pumps_on = (state_q != ST_OFF);
  wire drv_on = (state_q == ST_ON) & rail_3v;
  wire rx_on = AUTO_VARIANT ? 1'b1 : ~rx_gate_n;

  logic [CHANNELS-1:0] tx_out_q, rx_out_q, tx_oe_q, rx_oe_q;
  logic ready_q, lvl_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_out_q <= '0;
      rx_out_q <= '0;
      tx_oe_q <= '0;
      rx_oe_q <= '0;
      ready_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      tx_out_q <= ~tx_s2_q;
      rx_out_q <= ~rx_s2_q;
      tx_oe_q <= {CHANNELS{drv_on}};
      rx_oe_q <= {CHANNELS{rx_on}};
      ready_q <= pumps_on & rail_2v75;
      lvl_q <= |lvl_s2_q;
    end
  end

  assign tx_line_out_o = tx_out_q;
  assign tx_line_oe_o = tx_oe_q;
  assign rx_logic_out_o = rx_out_q;
  assign rx_logic_oe_o = rx_oe_q;
  assign pump_enable_o = pumps_on;
  assign ready_o = ready_q;
  assign line_level_present_o = lvl_q;
  assign status_o = '{ready: ready_q, level_present: lvl_q, pumps_on: pumps_on, shut_down: ~pumps_on};

endmodule

//--- rtl/line_xcvr_pkg.sv
package line_xcvr_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // wake delay after leaving shutdown, typical
  localparam int unsigned WAKE_DELAY_NS = 30_000;
  localparam int unsigned WAKE_DELAY_CYC = (WAKE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // inactivity window before automatic shutdown
  localparam int unsigned IDLE_SECONDS = 30;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_SECONDS) * longint'(CLK_HZ);

  localparam int unsigned WAKE_CNT_W = 11;
  localparam int unsigned IDLE_CNT_W = 31;

  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_WAKE = 3'h2,
    ST_ON   = 3'h4
  } pwr_state_type;

  // line driver outputs of one channel pair
  typedef struct packed {
    logic [1:0] data;
    logic [1:0] oe;
  } drv_bus_type;

  // status seen by local logic
  typedef struct packed {
    logic ready;
    logic level_present;
    logic pumps_on;
    logic shut_down;
  } status_type;

endpackage

//--- dv/line_xcvr_sva.sv
`timescale 1ns/100ps
module line_xcvr_sva (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic hold_awake_i,
  input wire logic hold_asleep_n_i,
  input wire logic [1:0] rx_level_valid_i,
  input wire logic neg_rail_at_3v_i,
  input wire logic neg_rail_at_2v75_i,
  input wire logic [1:0] tx_line_oe_o,
  input wire logic [1:0] rx_logic_oe_o,
  input wire logic pump_enable_o,
  input wire logic ready_o,
  input wire logic line_level_present_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  shut_quiet_a: assert property (!pump_enable_o [*4] |-> tx_line_oe_o == 2'h0 && !ready_o)
    else $error("drivers or ready on while off");
  rail_gate_a: assert property (!neg_rail_at_3v_i [*4] |-> tx_line_oe_o == 2'h0)
    else $error("drivers on with rail low");
  wake_delay_a: assert property ($rose(tx_line_oe_o[0]) |-> $past(pump_enable_o, 300))
    else $error("drivers on too soon");
  rx_always_a: assert property ($past(arst_n_i) |-> rx_logic_oe_o == 2'h3)
    else $error("rx output disabled");
  level_on_a: assert property ((rx_level_valid_i != 2'h0) [*4] |-> line_level_present_o)
    else $error("level flag low");
  level_off_a: assert property ((rx_level_valid_i == 2'h0) [*4] |-> !line_level_present_o)
    else $error("level flag high");
  force_on_a: assert property ((hold_awake_i && hold_asleep_n_i) [*6] |-> pump_enable_o)
    else $error("forced on but off");
  force_off_a: assert property (!hold_asleep_n_i [*4] |-> !pump_enable_o)
    else $error("forced off but on");
  ready_gate_a: assert property (!neg_rail_at_2v75_i [*4] |-> !ready_o)
    else $error("ready without rail");
endmodule
bind line_transceiver_shutdown_ctrl line_xcvr_sva u_line_xcvr_sva (.*);

//--- dv/rail_model.sv
`timescale 1ns/100ps
module rail_model #(parameter int RISE = 20) (
  input wire logic clock_i,
  input wire logic pump_enable_i,
  output logic rail_3v_o,
  output logic rail_2v75_o
);
  int cnt = 0;
  // rail collapses at once when the pumps stop
  always @(posedge clock_i) begin
    cnt <= pump_enable_i ? (cnt < RISE ? cnt + 1 : cnt) : 0;
  end
  assign rail_2v75_o = cnt >= RISE / 2;
  assign rail_3v_o = cnt >= RISE;
endmodule

//--- dv/line_transceiver_shutdown_ctrl_tb_top.sv
`timescale 1ns/100ps
module line_transceiver_shutdown_ctrl_tb_top;
  import line_xcvr_pkg::*;
  localparam int IDLE = 1500;
  logic clock_i = 0, arst_n_i = 0, tx_power_down_n_i = 1, rx_drive_gate_n_i = 0;
  logic hold_awake_i = 0, hold_asleep_n_i = 1, neg_rail_at_3v_i, neg_rail_at_2v75_i;
  logic [1:0] tx_logic_in_i = 0, rx_line_in_i = 0, rx_level_valid_i = 0;
  logic [1:0] tx_line_out_o, tx_line_oe_o, rx_logic_out_o, rx_logic_oe_o;
  logic pump_enable_o, ready_o, line_level_present_o;
  status_type status_o;
  int fails = 0, n_checks = 0, cyc = 0, t;
  always #12.5 clock_i = ~clock_i;
  line_transceiver_shutdown_ctrl #(.IDLE_CYCLES(IDLE)) u_line_transceiver_shutdown_ctrl (.*);
  rail_model u_rail_model (.clock_i(clock_i), .pump_enable_i(pump_enable_o),
    .rail_3v_o(neg_rail_at_3v_i), .rail_2v75_o(neg_rail_at_2v75_i));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic until_pump(logic v, int lim);
    t = 0;
    while (pump_enable_o !== v && t < lim) begin
      cycles(1);
      t++;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 15000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    cycles(2);
    arst_n_i = 1;
    hold_awake_i = 1;
    tx_logic_in_i = 2'h1;
    until_pump(1, 10);
    t = 0;
    while (tx_line_oe_o !== 2'h3 && t < 1300) begin
      cycles(1);
      t++;
    end
    chk("wake_cycles", t, 1201);
    chk("tx_out", tx_line_out_o, 2'h2);
    chk("ready", ready_o, 1);
    rx_line_in_i = 2'h2;
    rx_level_valid_i = 2'h1;
    cycles(IDLE);
    chk("held_on", pump_enable_o, 1);
    chk("rx_out", {rx_logic_oe_o, rx_logic_out_o}, 4'hD);
    chk("level", line_level_present_o, 1);
    $display("test force_on done");
    hold_asleep_n_i = 0;
    cycles(5);
    chk("forced_off", {pump_enable_o, ready_o, tx_line_oe_o, status_o.shut_down}, 5'h01);
    chk("level_forced", {line_level_present_o, rx_logic_oe_o}, 3'h7);
    $display("test force_off done");
    hold_awake_i = 0;
    cycles(IDLE + 20);
    hold_asleep_n_i = 1;
    cycles(6);
    chk("idle_off", pump_enable_o, 0);
    tx_logic_in_i = 2'h2;
    until_pump(1, 6);
    chk("tx_edge_wake", pump_enable_o, 1);
    cycles(1300);
    chk("auto_on", tx_line_oe_o, 2'h3);
    rx_line_in_i = 2'h0;
    until_pump(0, IDLE + 20);
    chk("idle_len", t >= IDLE && t <= IDLE + 8, 1);
    cycles(3);
    chk("auto_off", {tx_line_oe_o, ready_o, rx_logic_oe_o}, 5'h03);
    rx_line_in_i = 2'h1;
    until_pump(1, 6);
    chk("rx_edge_wake", pump_enable_o, 1);
    // hold_awake tied to the level flag: off when idle with no level, on when it returns
    rx_level_valid_i = 2'h0;
    repeat (IDLE + 20) begin
      cycles(1);
      hold_awake_i = line_level_present_o;
    end
    chk("tied_off", {pump_enable_o, line_level_present_o}, 2'h0);
    rx_level_valid_i = 2'h2;
    repeat (10) begin
      cycles(1);
      hold_awake_i = line_level_present_o;
    end
    chk("tied_on", {pump_enable_o, line_level_present_o}, 2'h3);
    $display("test auto done");
    end_of_test();
  end
endmodule
